// ===== rtl/adc_conversion_control.sv
// converter control top with apb register slave and interrupt
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module adc_conversion_control
  import adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_pin,
  input wire logic rc_osc_pin,
  input wire logic sleep_pin,
  output logic irq,
  output analog_out_t analog_ctl
);
`include "adc_cfg.svh"

  ////////////////////////////////////////////////////////////////////////////
  // pin function decode, bit n of the mask is channel n

  // returns {vref_external, analog mask} for a pin configuration code
  function automatic logic [8:0] pin_decode(input logic [2:0] code);
    logic [8:0] val;
    val = 9'h000;
    unique case (code)
      // all analog or port E digital, optionally with external ref
      3'b000: val = {1'b0, 8'hFF};
      3'b001: val = {1'b1, 8'hF7};
      3'b010: val = {1'b0, 8'h1F};
      3'b011: val = {1'b1, 8'h17};
      // reduced analog sets, and every pin digital for 11x
      3'b100: val = {1'b0, 8'h0B};
      3'b101: val = {1'b1, 8'h03};
      default: val = 9'h000;
    endcase
    return val;
  endfunction : pin_decode

  // word index of an aligned byte address, all ones when misaligned
  function automatic logic [9:0] word_index(input logic [11:0] addr);
    return (addr[1:0] == 2'b00) ? addr[11:2] : 10'h3FF;
  endfunction : word_index

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  top_reg_t st_reg;
  top_reg_t st_next;
  logic half_tick;
  logic eng_sampling;
  logic [7:0] eng_trial;
  logic [7:0] eng_result;
  logic eng_done;
  logic eng_run;
  logic [9:0] idx;
  logic setup_phase;
  logic wr_take;
  logic [7:0] main_view;
  logic [8:0] pin_dec;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  // half bit period tick source
  tad_tick_gen u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_sel(st_reg.clk_sel),
    .sleep_active(st_reg.sleep_s2),
    .rc_osc_pin(rc_osc_pin),
    .half_tick(half_tick)
  );

  // engine runs only while the converter is powered
  assign eng_run = st_reg.go && st_reg.power;

  // conversion sequencer
  sar_engine u_engine
  (
    .pclk(pclk),
    .presetn(presetn),
    .half_tick(half_tick),
    .run(eng_run),
    .comp_high(st_reg.comp_s2),
    .sampling(eng_sampling),
    .trial_code(eng_trial),
    .result(eng_result),
    .done(eng_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode helpers

  // zero wait slave: pready rises in the access cycle after setup
  assign idx = word_index(paddr);
  assign setup_phase = psel && !penable;
  assign wr_take = psel && penable && st_reg.pready && pwrite;

  // bit 1 of the main control register reads zero
  assign main_view = {st_reg.clk_sel, st_reg.chan, st_reg.go, 1'b0,
                      st_reg.power};

  assign pin_dec = pin_decode(st_reg.pin_cfg);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_next = st_reg;

    // two stage synchronisers for pins from outside the clock domain
    st_next.comp_s1 = comparator_pin;
    st_next.comp_s2 = st_reg.comp_s1;
    st_next.sleep_s1 = sleep_pin;
    st_next.sleep_s2 = st_reg.sleep_s1;

    // response is prepared during setup, valid in the access cycle
    st_next.pready = setup_phase;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    if (setup_phase)
    begin
      unique case (idx)
        `IDX_MAIN_CTRL:
          // go reads back as 1 while a conversion runs
          st_next.prdata = {24'h000000, main_view};
        `IDX_PIN_CFG:
          // upper pin configuration bits read zero
          st_next.prdata = {29'h00000000, st_reg.pin_cfg};
        `IDX_RESULT:
          st_next.prdata = {24'h000000, st_reg.result};
        `IDX_IRQ_STATUS:
          st_next.prdata = {31'h00000000, st_reg.done_flag};
        `IDX_IRQ_MASK:
          st_next.prdata = {31'h00000000, st_reg.done_mask};
        default:
          st_next.pslverr = 1'b1;
      endcase
    end

    // register writes take effect at the access edge
    if (wr_take)
    begin
      unique case (idx)
        `IDX_MAIN_CTRL:
        begin
          st_next.clk_sel = pwdata[`MAIN_CLKSEL_LSB +: 2];
          // channel code selects analog input N
          st_next.chan = pwdata[`MAIN_CHAN_LSB +: 3];
          st_next.power = pwdata[`MAIN_POWER_BIT];
          // a start while powered down is ignored
          // a start is taken only with the converter already on
          st_next.go = pwdata[`MAIN_GO_BIT] && st_reg.power &&
                       pwdata[`MAIN_POWER_BIT];
        end
        `IDX_PIN_CFG:
          st_next.pin_cfg = pwdata[`PIN_CFG_LSB +: 3];
        `IDX_RESULT:
          st_next.result = pwdata[7:0];
        `IDX_IRQ_MASK:
          st_next.done_mask = pwdata[`IRQ_DONE_BIT];
        `IDX_IRQ_STATUS:
        begin
          // only a written one clears the flag, reads leave it
          if (pwdata[`IRQ_DONE_BIT])
            st_next.done_flag = 1'b0;
        end
        default:
          st_next.done_flag = st_reg.done_flag;
      endcase
    end

    // completion loads result, clears go, sets the flag
    if (eng_done)
    begin
      st_next.result = eng_result;
      // a start written in the same cycle is kept for the next round
      if (!(wr_take && idx == `IDX_MAIN_CTRL && pwdata[`MAIN_GO_BIT]))
        st_next.go = 1'b0;
      // set wins over a clear in the same cycle
      st_next.done_flag = 1'b1;
    end

    // power off drops any conversion in flight
    if (!st_next.power)
      st_next.go = 1'b0;

    // registered pin function outputs follow the configuration
    st_next.pin_mask = pin_dec[7:0];
    st_next.vref_ext = pin_dec[8];

    // level interrupt while an enabled flag stands
    st_next.irq = st_next.done_flag && st_next.done_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // every implemented control bit clears on reset
      st_reg <= '0;
      st_reg.clk_sel <= 2'(`MAIN_CTRL_RST >> `MAIN_CLKSEL_LSB);
      st_reg.pin_cfg <= `PIN_CFG_RST;
      st_reg.result <= `RESULT_RST;
    end
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops except analog sampling, decoded from engine state and power

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;

  // analog side; a powered down converter draws no current
  assign analog_ctl.converter_enable = st_reg.power;
  assign analog_ctl.sampling = eng_sampling && st_reg.power;
  assign analog_ctl.channel = st_reg.chan;
  assign analog_ctl.trial_code = eng_trial;
  assign analog_ctl.analog_pin_mask = st_reg.pin_mask;
  assign analog_ctl.vref_external = st_reg.vref_ext;

endmodule : adc_conversion_control

// ===== rtl/adc_cfg.svh
// constants for the converter control block
// Contract
// - clock select 00/01/10 gives Tosc x2/x8/x32 bit period, 11 the RC clock
// - channel select code N routes analog channel N, codes 0 to 7
// - writing go while powered starts a conversion; go reads 1 while busy
// - on completion load result, clear go, set the done flag
// - main control bit 1 and pin config bits 7..3 read zero
// - all implemented control bits are read/write and reset to zero
// - pin codes 000..011 select all analog or port E digital, RA3 ref
// - code 100 RA0/1/3 analog, 101 RA0/1 with RA3 ref, 11x all digital
// - at least two bit periods after a conversion before acquiring again
// - one conversion takes nine and a half bit periods
// - clearing go mid conversion aborts, result kept, restart after 2 periods
// - conversion runs in sleep only when the RC clock is selected
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// register word indexes; byte address is four times the index
`define IDX_MAIN_CTRL 10'h01F
`define IDX_PIN_CFG 10'h09F
`define IDX_RESULT 10'h01E
`define IDX_IRQ_STATUS 10'h020
`define IDX_IRQ_MASK 10'h021

// field positions of the main control, pin configuration and interrupt registers
`define MAIN_CLKSEL_LSB 6
`define MAIN_CHAN_LSB 3
`define MAIN_GO_BIT 2
`define MAIN_POWER_BIT 0
`define PIN_CFG_LSB 0
`define IRQ_DONE_BIT 0

// reset values
`define MAIN_CTRL_RST 8'h00
`define PIN_CFG_RST 3'h0
`define RESULT_RST 8'h00

// clock select codes
`define CLKSEL_DIV2 2'b00
`define CLKSEL_DIV8 2'b01
`define CLKSEL_DIV32 2'b10
`define CLKSEL_RC 2'b11

// half bit period in core clocks minus one, per select code
`define HALF_DIV2 4'h0
`define HALF_DIV8 4'h3
`define HALF_DIV32 4'hF

// conversion timing in half bit periods: 9.5 periods, 2 periods gap
`define CONV_HALF_PERIODS 5'h13
`define RECOV_HALF_PERIODS 5'h04
`define FIRST_DECIDE 5'h03
`define LAST_DECIDE 5'h11

`endif

// ===== rtl/adc_pkg.sv
// types shared by the converter control modules
package adc_pkg;

  typedef enum logic [2:0] {
    ENG_ACQ = 3'b001,
    ENG_CONV = 3'b010,
    ENG_RECOV = 3'b100
  } eng_state_t;

  // signals toward the analog sample-and-hold and comparator
  typedef struct packed {
    logic converter_enable;
    logic sampling;
    logic [2:0] channel;
    logic [7:0] trial_code;
    logic [7:0] analog_pin_mask;
    logic vref_external;
  } analog_out_t;

  typedef struct packed {
    eng_state_t state;
    logic [4:0] cnt;
    logic [7:0] code;
    logic [7:0] probe;
    logic [7:0] result;
    logic done;
  } eng_reg_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic tick;
  } tick_reg_t;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic go;
    logic power;
    logic [2:0] pin_cfg;
    logic [7:0] result;
    logic done_flag;
    logic done_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_mask;
    logic vref_ext;
    logic comp_s1;
    logic comp_s2;
    logic sleep_s1;
    logic sleep_s2;
  } top_reg_t;

endpackage : adc_pkg

// ===== rtl/tad_tick_gen.sv
// half bit period tick generator for the converter
`timescale 1ns/1ps
module tad_tick_gen
  import adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] clk_sel,
  input wire logic sleep_active,
  input wire logic rc_osc_pin,
  output logic half_tick
);
`include "adc_cfg.svh"

  tick_reg_t st_reg;
  tick_reg_t st_next;
  logic [3:0] limit;
  logic halted;

  ////////////////////////////////////////////////////////////////////////////
  // divider and rc edge detect
  always_comb
  begin
    st_next = st_reg;
    // bit period source chosen by the select field
    unique case (clk_sel)
      `CLKSEL_DIV2: limit = `HALF_DIV2;
      `CLKSEL_DIV8: limit = `HALF_DIV8;
      default: limit = `HALF_DIV32;
    endcase
    // core oscillator stops in sleep, only the rc clock keeps running
    halted = sleep_active && (clk_sel != `CLKSEL_RC);
    st_next.rc_s1 = rc_osc_pin;
    st_next.rc_s2 = st_reg.rc_s1;
    st_next.rc_s3 = st_reg.rc_s2;
    st_next.tick = 1'b0;
    if (clk_sel == `CLKSEL_RC)
    begin
      // each rc edge is half a bit period
      st_next.cnt = 4'h0;
      st_next.tick = st_reg.rc_s2 ^ st_reg.rc_s3;
    end
    else if (halted)
      st_next.cnt = 4'h0;
    else if (st_reg.cnt >= limit)
    begin
      st_next.cnt = 4'h0;
      st_next.tick = 1'b1;
    end
    else
      st_next.cnt = st_reg.cnt + 4'h1;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign half_tick = st_reg.tick;

endmodule : tad_tick_gen

// ===== rtl/sar_engine.sv
// successive approximation sequencer for the converter
`timescale 1ns/1ps
module sar_engine
  import adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic half_tick,
  input wire logic run,
  input wire logic comp_high,
  output logic sampling,
  output logic [7:0] trial_code,
  output logic [7:0] result,
  output logic done
);
`include "adc_cfg.svh"

  eng_reg_t st_reg;
  eng_reg_t st_next;
  logic [4:0] cnt_inc;
  logic [7:0] kept;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    cnt_inc = st_reg.cnt + 5'h01;
    // keep the trial bit only when the input is above the trial level
    kept = comp_high ? st_reg.code : (st_reg.code & ~st_reg.probe);
    unique case (st_reg.state)
      ENG_ACQ:
      begin
        if (run)
        begin
          st_next.state = ENG_CONV;
          st_next.cnt = 5'h00;
          st_next.code = 8'h80;
          st_next.probe = 8'h80;
        end
      end
      ENG_CONV:
      begin
        // go cleared: abort, result untouched, recovery gap follows
        if (!run)
        begin
          st_next.state = ENG_RECOV;
          st_next.cnt = 5'h00;
        end
        else if (half_tick)
        begin
          st_next.cnt = cnt_inc;
          if (cnt_inc[0] && cnt_inc >= `FIRST_DECIDE &&
              cnt_inc <= `LAST_DECIDE)
          begin
            st_next.probe = st_reg.probe >> 1;
            st_next.code = kept | (st_reg.probe >> 1);
          end
          // done after nine and a half bit periods
          if (cnt_inc == `CONV_HALF_PERIODS)
          begin
            st_next.result = st_reg.code;
            st_next.done = 1'b1;
            st_next.state = ENG_RECOV;
            st_next.cnt = 5'h00;
          end
        end
      end
      ENG_RECOV:
      begin
        // two bit periods before the hold capacitor reconnects
        if (half_tick)
        begin
          st_next.cnt = cnt_inc;
          if (cnt_inc == `RECOV_HALF_PERIODS)
            st_next.state = ENG_ACQ;
        end
      end
      default:
        st_next.state = ENG_ACQ;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.state <= ENG_ACQ;
    end
    else
      st_reg <= st_next;
  end

  assign sampling = (st_reg.state == ENG_ACQ);
  assign trial_code = st_reg.code;
  assign result = st_reg.result;
  assign done = st_reg.done;

endmodule : sar_engine

// ===== tb/adc_ctl_checker.sv
// concurrent checks on the ports of the converter control top
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_ctl_checker
  import adc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire analog_out_t analog_ctl
);
  localparam logic [11:0] A_MAIN = {`IDX_MAIN_CTRL, 2'b00};
  localparam logic [11:0] A_PIN = {`IDX_PIN_CFG, 2'b00};
  localparam logic [11:0] A_MASK = {`IDX_IRQ_MASK, 2'b00};
  // completed transfer and decode of the mapped words
  wire acc = psel && penable && pready;
  wire known = paddr inside {A_MAIN, A_PIN, A_MASK, 12'h078, 12'h080};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence conv_start;
    $fell(analog_ctl.sampling) && analog_ctl.converter_enable;
  endsequence
  sequence mask_off;
    acc && pwrite && paddr == A_MASK && !pwdata[0];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  a_err_decode: assert property (acc |-> pslverr == !known)
    else $error("slave error does not match address decode");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error without pready");
  a_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside access");
  a_main_rsvd: assert property (acc && !pwrite && paddr == A_MAIN
    |-> prdata[31:8] == 24'h0 && !prdata[1])
    else $error("unused main control bits read nonzero");
  a_pin_rsvd: assert property (acc && !pwrite && paddr == A_PIN
    |-> prdata[31:3] == 29'h0)
    else $error("unused pin config bits read nonzero");
  a_mask_irq: assert property (mask_off |-> ##2 !irq)
    else $error("interrupt stays high after masking");
  a_first_trial: assert property (conv_start |->
    analog_ctl.trial_code == 8'h80)
    else $error("conversion does not begin at the top bit");
  a_pin_map: assert property (analog_ctl.analog_pin_mask inside
    {8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00} &&
    analog_ctl.vref_external == (analog_ctl.analog_pin_mask inside
    {8'hF7, 8'h17, 8'h03}))
    else $error("pin map or reference outside the legal set");
  a_off_idle: assert property (acc && !pwrite && paddr == A_MAIN &&
    !prdata[0] |-> !prdata[2])
    else $error("go reads set while powered down");
endmodule : adc_ctl_checker
bind adc_conversion_control adc_ctl_checker adc_ctl_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .analog_ctl(analog_ctl));

// ===== tb/analog_frontend_model.sv
// behavioural sample-and-hold and comparator facing the converter
`timescale 1ns/1ps
module analog_frontend_model
  import adc_pkg::*;
(
  input wire logic pclk,
  input wire analog_out_t ctl,
  input wire logic [7:0] level,
  output logic comparator
);
  logic [7:0] held = 8'h00;
  logic junk = 1'b0;
  // cap follows input only while connected
  always @(posedge pclk)
  begin
    if (ctl.sampling)
      held <= level;
    junk <= ~junk;
  end
  // half a step offset makes the code equal the held level; off means noise
  assign comparator = ctl.converter_enable ?
    ({held, 1'b1} > {ctl.trial_code, 1'b0}) : junk;
endmodule : analog_frontend_model

// ===== tb/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_cfg.svh"
module tb_top
  import adc_pkg::*;
;
  localparam logic [11:0] A_MAIN = {`IDX_MAIN_CTRL, 2'b00};
  localparam logic [11:0] A_PIN = {`IDX_PIN_CFG, 2'b00};
  localparam logic [11:0] A_RES = {`IDX_RESULT, 2'b00};
  localparam logic [11:0] A_STAT = {`IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MASK = {`IDX_IRQ_MASK, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic rc = 0, sleep_pin = 0, comp, pready, pslverr, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] level = 0, last_res = 0;
  analog_out_t actl;
  logic [32:0] exp_q[$];
  logic [8:0] pin_tbl[8] = '{9'h0FF, 9'h1F7, 9'h01F, 9'h117, 9'h00B, 9'h103,
    9'h000, 9'h000};
  int fail_count = 0, num_checks = 0;
  // core clock and a free running rc oscillator of unrelated phase
  initial forever #25 pclk = ~pclk;
  initial forever #230 rc = ~rc;
  adc_conversion_control adc_conversion_control_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_pin(comp), .rc_osc_pin(rc),
    .sleep_pin(sleep_pin), .irq(irq), .analog_ctl(actl));
  analog_frontend_model analog_frontend_model_inst (.pclk(pclk),
    .ctl(actl), .level(level), .comparator(comp));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task conclude;
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // one transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // read answers are matched against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  // one conversion on a random channel; half is the half period in cycles
  task convert(input logic [1:0] sel, input int half);
    logic [2:0] ch;
    logic [7:0] v;
    int n;
    ch = 3'($urandom);
    v = 8'($urandom);
    n = 0;
    apb(1'b1, A_MAIN, {24'h0, sel, ch, 3'b001});
    level <= v;
    // acquisition wait, also outlasts the recovery gap of the last run
    repeat (80) @(posedge pclk);
    apb(1'b1, A_MAIN, {24'h0, sel, ch, 3'b101});
    rd(A_MAIN, {25'h0, sel, ch, 3'b101});
    chk({30'h0, actl.channel}, {30'h0, ch});
    level <= ~v;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (half > 0)
      chk({32'h0, n >= 18 * half + 1 && n <= 19 * half}, 33'h1);
    chk({32'h0, actl.sampling}, 33'h0);
    rd(A_RES, {25'h0, v});
    rd(A_MAIN, {25'h0, sel, ch, 3'b001});
    rd(A_STAT, 33'h1);
    apb(1'b1, A_STAT, 32'h1);
    rd(A_STAT, 33'h0);
    chk({32'h0, irq}, 33'h0);
    last_res = v;
  endtask : convert
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(13));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (pin_tbl[i])
      if (i < 5)
        rd(i == 0 ? A_MAIN : i == 1 ? A_PIN : i == 2 ? A_RES
          : i == 3 ? A_STAT : A_MASK, 33'h0);
    rd(12'h100, {1'b1, 32'h0});
    rd(12'h07D, {1'b1, 32'h0});
    apb(1'b1, A_MAIN, 32'hFFFF_FFFB);
    rd(A_MAIN, 33'h0F9);
    apb(1'b1, A_PIN, 32'hFFFF_FFFF);
    rd(A_PIN, 33'h007);
    apb(1'b1, A_MAIN, 32'h0);
    apb(1'b1, A_MAIN, 32'h4);
    rd(A_MAIN, 33'h0);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, A_PIN, 32'(c));
      repeat (2) @(posedge pclk);
      chk({24'h0, actl.vref_external, actl.analog_pin_mask},
        {24'h0, pin_tbl[c]});
    end
    // code 000 leaves every channel analog; pin directions are outside
    apb(1'b1, A_PIN, 32'h0);
    apb(1'b1, A_MASK, 32'h1);
    rd(A_MASK, 33'h1);
    repeat (3) convert(2'b01, 4);
    repeat (2) convert(2'b10, 16);
    sleep_pin <= 1'b1;
    convert(2'b11, 0);
    sleep_pin <= 1'b0;
    // abort mid conversion keeps old result
    apb(1'b1, A_MAIN, {24'h0, 2'b10, 3'd2, 3'b101});
    // long enough that the earlier recovery is over and conversion runs
    repeat (120) @(posedge pclk);
    apb(1'b1, A_MAIN, {24'h0, 2'b10, 3'd2, 3'b001});
    repeat (40) @(posedge pclk);
    chk({32'h0, actl.sampling}, 33'h0);
    repeat (32) @(posedge pclk);
    chk({32'h0, actl.sampling}, 33'h1);
    rd(A_RES, {25'h0, last_res});
    rd(A_STAT, 33'h0);
    // core clock stalls in sleep; flag set but masked
    apb(1'b1, A_MASK, 32'h0);
    level <= 8'h5A;
    sleep_pin <= 1'b1;
    apb(1'b1, A_MAIN, {24'h0, 2'b10, 3'd4, 3'b101});
    repeat (600) @(posedge pclk);
    rd(A_MAIN, {25'h0, 2'b10, 3'd4, 3'b101});
    sleep_pin <= 1'b0;
    repeat (400) @(posedge pclk);
    rd(A_STAT, 33'h1);
    chk({32'h0, irq}, 33'h0);
    rd(A_RES, 33'h05A);
    conclude();
  end
endmodule : tb_top
